// ### dvpo_map.svh
// Register map, field positions, reset values and counts of the video port.
// Assumes inclusion by the port module; definitions only.
`ifndef DVPO_MAP_SVH
`define DVPO_MAP_SVH

// Register offsets
`define DVPO_BASE_ADDR          16'h4700
`define DVPO_FSW_ROWS_HI        16'h4700
`define DVPO_FSW_ROWS_LO        16'h4701
`define DVPO_FSW_CLKS_HI        16'h4702
`define DVPO_FSW_CLKS_LO        16'h4703
`define DVPO_FSD_TOP            16'h4704
`define DVPO_FSD_MID            16'h4705
`define DVPO_FSD_LOW            16'h4706
`define DVPO_POLARITY           16'h4707
`define DVPO_TEST_CTRL          16'h4708
`define DVPO_SWAP_SEL           16'h4709
`define DVPO_CLK_INV            16'h470A
`define DVPO_CHAN_SEL           16'h470B
`define DVPO_SYNC_CTRL          16'h470C
`define DVPO_NUM_REGS           13

// Reset values
`define DVPO_RST_FSW_ROWS_HI    8'h00
`define DVPO_RST_FSW_ROWS_LO    8'h00
`define DVPO_RST_FSW_CLKS_HI    8'h02
`define DVPO_RST_FSW_CLKS_LO    8'h00
`define DVPO_RST_FSD_TOP        8'h00
`define DVPO_RST_FSD_MID        8'h01
`define DVPO_RST_FSD_LOW        8'h00
`define DVPO_RST_POLARITY       8'h00
`define DVPO_RST_TEST_CTRL      8'h00
`define DVPO_RST_SWAP_SEL       8'h00
`define DVPO_RST_CLK_INV        8'h00
`define DVPO_RST_CHAN_SEL       8'h0F
`define DVPO_RST_SYNC_CTRL      8'h01

// Field positions
`define DVPO_POL_INVERT_BIT     6
`define DVPO_POL_LVALID_BIT     2
`define DVPO_POL_FSYNC_BIT      1
`define DVPO_TEST_SLOW_BIT      3
`define DVPO_TEST_TEN_BIT       2
`define DVPO_TEST_EIGHT_BIT     1
`define DVPO_TEST_EN_BIT        0
`define DVPO_SWAP_SHIFT_BIT     5
`define DVPO_CLK_OUT_INV_BIT    1
`define DVPO_CLK_IN_INV_BIT     0
`define DVPO_SYNC_BYPASS_BIT    1
`define DVPO_SYNC_FS_EN_BIT     0

// Counts
`define DVPO_DATA_W             12
`define DVPO_FIFO_DEPTH         16
`define DVPO_ROW_PERIOD         2200

`endif

// ### dvpo_pkg.sv
// Types shared by the parallel video output port.
// Assumes nothing beyond the map header for numbers.
package dvpo_pkg;

  // Frame sync sequencer states
  typedef enum logic [1:0] {
    FS_IDLE,
    FS_DELAY,
    FS_PULSE
  } dvpo_fs_state_t;

  typedef logic [7:0] dvpo_byte_t;

endpackage

// ### dvpo_port.sv
// Parallel 12-bit video output port: register file, clock-crossing FIFO,
// frame sync sequencer, test patterns and pin conditioning.
// Assumes a byte register port and pixel source on clk_sys, and the
// pixel PLL clock on link_clk running freely.
//
// How it works
// - Drive 12-bit words from either HDR combination.
// - Frame sync marks start of each frame.
// - Line valid exactly while pixels are driven.
// - Frame sync follows start-of-frame by 24-bit delay.
// - Width is rows times row period plus clocks.
// - Width spans one clock up to whole frame.
// - Test enable drives walking-one pattern.
// - Image bits map straight onto pins 11..0.
// - Polarity bits: zero active high, one low.
// - Invert bit flips the output data bits.
// - Slow test advances pattern every second clock.
// - Ten-bit and eight-bit pattern variants selectable.
// - Shift bit picks the walking-one direction.
// - Invert outgoing pixel clock or incoming PLL clock.
// - Four lane select bits, all set after reset.
// - Bypass bit one, frame sync enable bit zero.
`include "dvpo_map.svh"
`timescale 1ns/100ps

// Asynchronous FIFO with gray pointers; write on wclk, read on rclk
module dvpo_fifo #(
  parameter int W     = `DVPO_DATA_W,
  parameter int DEPTH = `DVPO_FIFO_DEPTH
) (
  input  wire logic         wclk,
  input  wire logic         rclk,
  input  wire logic         rst,
  input  wire logic         w_valid,
  output logic              w_ready,
  input  wire logic [W-1:0] w_data,
  output logic              r_valid,
  input  wire logic         r_ready,
  output logic [W-1:0]      r_data
);
  localparam int AW = $clog2(DEPTH);

  initial
  begin
    if (DEPTH < 4 || (1 << AW) != DEPTH)
      $error("FIFO depth must be a power of two");
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wbin_reg, wgray_reg, rbin_reg, rgray_reg;
  logic [AW:0]  rgray_s1_reg, rgray_s2_reg, wgray_s1_reg, wgray_s2_reg;
  logic         full_reg, empty_reg;

  // Pointer arithmetic
  wire          push       = w_valid & ~full_reg;
  wire          pop        = r_ready & ~empty_reg;
  wire [AW:0]   wbin_next  = wbin_reg + {{AW{1'b0}}, push};
  wire [AW:0]   wgray_next = wbin_next ^ (wbin_next >> 1);
  wire [AW:0]   rbin_next  = rbin_reg + {{AW{1'b0}}, pop};
  wire [AW:0]   rgray_next = rbin_next ^ (rbin_next >> 1);
  wire          full_next  = wgray_next ==
                  {~rgray_s2_reg[AW:AW-1], rgray_s2_reg[AW-2:0]};
  wire          empty_next = rgray_next == wgray_s2_reg;

  assign w_ready = ~full_reg;
  assign r_valid = ~empty_reg;
  assign r_data  = mem[rbin_reg[AW-1:0]];

  // Storage
  always_ff @(posedge wclk)
  begin
    if (push)
      mem[wbin_reg[AW-1:0]] <= w_data;
  end

  // Write side pointers
  always_ff @(posedge wclk or posedge rst)
  begin
    if (rst)
    begin
      wbin_reg     <= '0;
      wgray_reg    <= '0;
      rgray_s1_reg <= '0;
      rgray_s2_reg <= '0;
      full_reg     <= 1'b0;
    end
    else
    begin
      wbin_reg     <= wbin_next;
      wgray_reg    <= wgray_next;
      rgray_s1_reg <= rgray_reg;
      rgray_s2_reg <= rgray_s1_reg;
      full_reg     <= full_next;
    end
  end

  // Read side pointers
  always_ff @(posedge rclk or posedge rst)
  begin
    if (rst)
    begin
      rbin_reg     <= '0;
      rgray_reg    <= '0;
      wgray_s1_reg <= '0;
      wgray_s2_reg <= '0;
      empty_reg    <= 1'b1;
    end
    else
    begin
      rbin_reg     <= rbin_next;
      rgray_reg    <= rgray_next;
      wgray_s1_reg <= wgray_reg;
      wgray_s2_reg <= wgray_s1_reg;
      empty_reg    <= empty_next;
    end
  end
endmodule

module dvpo_port #(
  parameter int DATA_W     = `DVPO_DATA_W,
  parameter int FIFO_DEPTH = `DVPO_FIFO_DEPTH,
  parameter int ROW_PERIOD = `DVPO_ROW_PERIOD
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              link_clk,
  input  wire logic [15:0]       cfg_addr,
  input  wire logic              cfg_wr,
  input  wire logic              cfg_rd,
  input  wire dvpo_pkg::dvpo_byte_t cfg_wdata,
  output dvpo_pkg::dvpo_byte_t   cfg_rdata,
  input  wire logic              four_capture_sel,
  input  wire logic [DATA_W-1:0] three_capture_combined,
  input  wire logic [DATA_W-1:0] four_capture_combined,
  input  wire logic              pix_valid,
  output logic                   pix_ready,
  input  wire logic              sof_pulse,
  output logic [DATA_W-1:0]      vid_data,
  output logic                   vid_line_valid,
  output logic                   vid_frame_sync,
  output logic                   vid_pclk
);
  import dvpo_pkg::*;

  localparam int CFG_W = `DVPO_NUM_REGS * 8;

  initial
  begin
    if (DATA_W != 12 || ROW_PERIOD < 1)
      $error("Port serves a 12-bit bus and a non-zero row period");
  end

  // Register index of a byte address, NUM_REGS when unmapped
  function automatic logic [3:0] reg_index(input logic [15:0] a);
    logic [15:0] d;
    d = a - `DVPO_BASE_ADDR;
    reg_index = (d < `DVPO_NUM_REGS) ? d[3:0] : 4'(`DVPO_NUM_REGS);
  endfunction

  // Reset value by index
  function automatic dvpo_byte_t reset_value(input int i);
    unique case (i)
      0:  reset_value = `DVPO_RST_FSW_ROWS_HI;
      1:  reset_value = `DVPO_RST_FSW_ROWS_LO;
      2:  reset_value = `DVPO_RST_FSW_CLKS_HI;
      3:  reset_value = `DVPO_RST_FSW_CLKS_LO;
      4:  reset_value = `DVPO_RST_FSD_TOP;
      5:  reset_value = `DVPO_RST_FSD_MID;
      6:  reset_value = `DVPO_RST_FSD_LOW;
      7:  reset_value = `DVPO_RST_POLARITY;
      8:  reset_value = `DVPO_RST_TEST_CTRL;
      9:  reset_value = `DVPO_RST_SWAP_SEL;
      10: reset_value = `DVPO_RST_CLK_INV;
      11: reset_value = `DVPO_RST_CHAN_SEL;
      default: reset_value = `DVPO_RST_SYNC_CTRL;
    endcase
  endfunction

  // Next walking-one value within the lowest n bits, either direction
  function automatic logic [11:0] walk_next(input logic [11:0] cur,
                                            input int n,
                                            input logic rev);
    logic [11:0] mask;
    logic [11:0] nxt;
    mask = 12'((1 << n) - 1);
    if (rev)
      nxt = (cur & mask) >> 1;
    else
      nxt = ((cur & mask) << 1) & mask;
    if (nxt == 12'h000)
      nxt = rev ? 12'(1 << (n - 1)) : 12'h001;
    walk_next = nxt;
  endfunction

  // Register file, system clock side
  dvpo_byte_t regs_reg [`DVPO_NUM_REGS];
  dvpo_byte_t rdata_reg;
  wire  [3:0] wr_idx = reg_index(cfg_addr);

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < `DVPO_NUM_REGS; i++)
        regs_reg[i] <= reset_value(i);
    end
    else if (cfg_wr && wr_idx != 4'(`DVPO_NUM_REGS))
      regs_reg[wr_idx] <= cfg_wdata;
  end

  // Read answer one cycle after the strobe, zero when unmapped
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rdata_reg <= 8'h00;
    else if (cfg_rd)
      rdata_reg <= (wr_idx != 4'(`DVPO_NUM_REGS)) ? regs_reg[wr_idx]
                                                 : 8'h00;
  end

  assign cfg_rdata = rdata_reg;

  // Flatten the configuration for the crossing
  logic [CFG_W-1:0] cfg_flat;
  genvar g;
  generate
    for (g = 0; g < `DVPO_NUM_REGS; g++)
    begin : g_flat
      assign cfg_flat[g*8 +: 8] = regs_reg[g];
    end
  endgenerate

  // Start-of-frame event as a toggle
  logic sof_tgl_reg;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      sof_tgl_reg <= 1'b0;
    else if (sof_pulse)
      sof_tgl_reg <= ~sof_tgl_reg;
  end

  // Pixel source selection feeding the FIFO
  wire [DATA_W-1:0] src_word = four_capture_sel ? four_capture_combined
                                                : three_capture_combined;
  logic             fifo_rvalid;
  logic             fifo_pop;
  logic [DATA_W-1:0] fifo_rdata;

  dvpo_fifo #(
    .W     (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .wclk    (clk_sys),
    .rclk    (link_clk),
    .rst     (rst),
    .w_valid (pix_valid),
    .w_ready (pix_ready),
    .w_data  (src_word),
    .r_valid (fifo_rvalid),
    .r_ready (fifo_pop),
    .r_data  (fifo_rdata)
  );

  // Link side: configuration and event synchronisers
  logic [CFG_W-1:0] cfg_s1_reg, cfg_s2_reg;
  logic             sof_s1_reg, sof_s2_reg, sof_s3_reg;

  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_s1_reg <= '0;
      cfg_s2_reg <= '0;
      sof_s1_reg <= 1'b0;
      sof_s2_reg <= 1'b0;
      sof_s3_reg <= 1'b0;
    end
    else
    begin
      cfg_s1_reg <= cfg_flat;
      cfg_s2_reg <= cfg_s1_reg;
      sof_s1_reg <= sof_tgl_reg;
      sof_s2_reg <= sof_s1_reg;
      sof_s3_reg <= sof_s2_reg;
    end
  end

  // Decoded link-side fields
  wire        sof_evt   = sof_s2_reg ^ sof_s3_reg;
  wire [15:0] w_rows    = {cfg_s2_reg[0*8 +: 8], cfg_s2_reg[1*8 +: 8]};
  wire [15:0] w_clks    = {cfg_s2_reg[2*8 +: 8], cfg_s2_reg[3*8 +: 8]};
  wire [23:0] fs_delay  = {cfg_s2_reg[4*8 +: 8], cfg_s2_reg[5*8 +: 8],
                           cfg_s2_reg[6*8 +: 8]};
  wire [7:0]  pol       = cfg_s2_reg[7*8 +: 8];
  wire [7:0]  tst       = cfg_s2_reg[8*8 +: 8];
  wire [7:0]  swp       = cfg_s2_reg[9*8 +: 8];
  wire [7:0]  cinv      = cfg_s2_reg[10*8 +: 8];
  wire [3:0]  lane_zero_select_grp = cfg_s2_reg[11*8 +: 4];
  wire [7:0]  syn       = cfg_s2_reg[12*8 +: 8];
  wire        test_on   = tst[`DVPO_TEST_EN_BIT];
  wire        pattern_ten_bit   = tst[`DVPO_TEST_TEN_BIT];
  wire        pattern_eight_bit = tst[`DVPO_TEST_EIGHT_BIT];

  // Width in rows converted with the row period, at least one clock
  wire [39:0] w_prod  = 40'(w_rows) * 40'(ROW_PERIOD);
  wire [39:0] w_sum   = w_prod + 40'(w_clks);
  wire [39:0] w_total = (w_sum == 40'h0) ? 40'h1 : w_sum;

  // Pixel clock phase and tick; one tick per output pixel period
  logic phase_reg;
  wire  tick = phase_reg == cinv[`DVPO_CLK_IN_INV_BIT];

  // Frame sync sequencer
  dvpo_fs_state_t fs_state_reg;
  logic [39:0]    fs_cnt_reg;
  wire            bypass = syn[`DVPO_SYNC_BYPASS_BIT];

  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
    begin
      fs_state_reg <= FS_IDLE;
      fs_cnt_reg   <= 40'h0;
    end
    else if (sof_evt)
    begin
      // Every frame start restarts delay and width
      fs_state_reg <= (bypass || fs_delay == 24'h0) ? FS_PULSE
                                                    : FS_DELAY;
      fs_cnt_reg   <= bypass ? 40'h1
                    : (fs_delay == 24'h0) ? w_total : 40'(fs_delay);
    end
    else if (tick)
    begin
      unique case (fs_state_reg)
        FS_IDLE:
          fs_cnt_reg <= 40'h0;
        FS_DELAY:
        begin
          if (fs_cnt_reg == 40'h1)
          begin
            fs_state_reg <= FS_PULSE;
            fs_cnt_reg   <= w_total;
          end
          else
            fs_cnt_reg <= fs_cnt_reg - 40'h1;
        end
        FS_PULSE:
        begin
          if (fs_cnt_reg == 40'h1)
            fs_state_reg <= FS_IDLE;
          fs_cnt_reg <= fs_cnt_reg - 40'h1;
        end
      endcase
    end
  end

  // Walking-one generator
  logic [11:0] walk_reg;
  logic        slow_reg;
  wire  [4:0]  walk_n  = pattern_ten_bit ? 5'h0A
                       : pattern_eight_bit ? 5'h08 : 5'h0C;
  wire         walk_go = tick & test_on &
                         (~tst[`DVPO_TEST_SLOW_BIT] | slow_reg);

  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
    begin
      walk_reg <= 12'h001;
      slow_reg <= 1'b0;
    end
    else
    begin
      if (tick)
        slow_reg <= ~slow_reg;
      if (walk_go)
        walk_reg <= walk_next(walk_reg, walk_n,
                              swp[`DVPO_SWAP_SHIFT_BIT]);
    end
  end

  // Output word selection and conditioning
  assign fifo_pop = tick & ~test_on & fifo_rvalid;
  wire        drive    = test_on | fifo_pop;
  wire [11:0] raw_word = test_on ? walk_reg : fifo_rdata;
  wire [11:0] lane_msk = {{3{lane_zero_select_grp[3]}},
                          {3{lane_zero_select_grp[2]}},
                          {3{lane_zero_select_grp[1]}},
                          {3{lane_zero_select_grp[0]}}};
  wire [11:0] inv_word = raw_word ^ {12{pol[`DVPO_POL_INVERT_BIT]}};
  wire [11:0] out_word = drive ? (inv_word & lane_msk) : 12'h000;
  wire        fs_act   = syn[`DVPO_SYNC_FS_EN_BIT] &
                         (fs_state_reg == FS_PULSE);
  wire        lv_pin   = drive ^ pol[`DVPO_POL_LVALID_BIT];
  wire        fs_pin   = fs_act ^ pol[`DVPO_POL_FSYNC_BIT];

  // Pins, launched on the tick so the receiver samples mid period
  logic [11:0] data_reg;
  logic        lv_reg, fs_reg, pclk_reg;

  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
    begin
      phase_reg <= 1'b0;
      pclk_reg  <= 1'b0;
      data_reg  <= 12'h000;
      lv_reg    <= 1'b0;
      fs_reg    <= 1'b0;
    end
    else
    begin
      phase_reg <= ~phase_reg;
      pclk_reg  <= phase_reg ^ cinv[`DVPO_CLK_OUT_INV_BIT];
      if (tick)
      begin
        data_reg <= out_word;
        lv_reg   <= lv_pin;
        fs_reg   <= fs_pin;
      end
    end
  end

  assign vid_data       = data_reg;
  assign vid_line_valid = lv_reg;
  assign vid_frame_sync = fs_reg;
  assign vid_pclk       = pclk_reg;
endmodule

// ### dvpo_port_checker.sv
// Pin checks of the parallel video port, bound to its top module.
// Assumes registers and link timing as handed over with the port.
`timescale 1ns/100ps
module dvpo_port_checker #(
  parameter int DATA_W = 12
) (
  input wire logic                 clk_sys,
  input wire logic                 rst,
  input wire logic                 link_clk,
  input wire logic [15:0]          cfg_addr,
  input wire logic                 cfg_wr,
  input wire logic                 cfg_rd,
  input wire dvpo_pkg::dvpo_byte_t cfg_wdata,
  input wire dvpo_pkg::dvpo_byte_t cfg_rdata,
  input wire logic                 pix_valid,
  input wire logic                 pix_ready,
  input wire logic [DATA_W-1:0]    vid_data,
  input wire logic                 vid_line_valid,
  input wire logic                 vid_frame_sync
);
  import dvpo_pkg::*;
  // Register window decode
  wire mapped = (cfg_addr >= 16'h4700) && (cfg_addr <= 16'h470C);
  sequence wr_then_rd;
    cfg_wr && mapped ##1 !cfg_wr ##1 cfg_rd && !cfg_wr &&
      cfg_addr == $past(cfg_addr, 2);
  endsequence
  sequence idle_three;
    (!pix_valid) [*3] ##0 pix_ready;
  endsequence
  write_readback_a: assert property (@(posedge clk_sys) disable iff (rst)
    wr_then_rd |=> cfg_rdata == $past(cfg_wdata, 3))
    else $error("readback differs from written byte");
  unmapped_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    cfg_rd && !mapped |=> cfg_rdata == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    !cfg_rd |=> $stable(cfg_rdata))
    else $error("read data moved without a read");
  ready_reset_a: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(rst) |-> pix_ready)
    else $error("pixel input not ready after reset");
  ready_kept_a: assert property (@(posedge clk_sys) disable iff (rst)
    idle_three |=> pix_ready)
    else $error("pixel input refused without pushes");
  data_tick_a: assert property (@(posedge link_clk) disable iff (rst)
    $changed(vid_data) |=> $stable(vid_data))
    else $error("data changed twice in one pixel");
  line_tick_a: assert property (@(posedge link_clk) disable iff (rst)
    $changed(vid_line_valid) |=> !$changed(vid_line_valid))
    else $error("line valid changed off a pixel tick");
  sync_tick_a: assert property (@(posedge link_clk) disable iff (rst)
    $changed(vid_frame_sync) |-> ##1 vid_frame_sync == $past(vid_frame_sync))
    else $error("frame sync changed off a pixel tick");
endmodule

bind dvpo_port dvpo_port_checker #(.DATA_W(DATA_W)) chk_u (
  .clk_sys, .rst, .link_clk, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_wdata,
  .cfg_rdata, .pix_valid, .pix_ready, .vid_data, .vid_line_valid,
  .vid_frame_sync
);

// ### dvpo_rx_model.sv
// Backend receiver model taking the parallel video stream.
// Assumes link_clk is the pixel PLL clock feeding the port.
`timescale 1ns/100ps
module dvpo_rx_model (
  input wire logic        link_clk,
  input wire logic        clr,
  input wire logic        lv_low,
  input wire logic        fs_low,
  input wire logic [11:0] vid_data,
  input wire logic        vid_line_valid,
  input wire logic        vid_frame_sync
);
  logic [11:0] words[$];
  int          edges, fs_count, fs_len, fs_at;
  logic        ph, fs_q;
  // Active levels follow the programmed polarity
  wire lv_act = vid_line_valid ^ lv_low;
  wire fs_act = vid_frame_sync ^ fs_low;
  // One sample per pixel period, only while line valid is active
  always @(negedge link_clk)
  begin
    if (clr)
    begin
      words.delete();
      edges = 0;
      fs_count = 0;
      fs_len = 0;
      ph = 0;
    end
    else
    begin
      edges++;
      if (lv_act)
      begin
        if (!ph)
          words.push_back(vid_data);
        ph = !ph;
      end
      else
        ph = 0;
      if (fs_act)
      begin
        if (!fs_q)
        begin
          fs_count++;
          fs_at = edges;
          fs_len = 0;
        end
        fs_len++;
      end
    end
    fs_q = fs_act;
  end
endmodule

// ### tb_parallel_video_output_port.sv
// Self-checking bench of the video port with a receiver model.
// Assumes the checker binds itself; link clock unrelated in phase.
`timescale 1ns/100ps
module tb_parallel_video_output_port;
  import dvpo_pkg::*;
  localparam int RP = 4;
  localparam logic [7:0] RV [13] = '{8'h00, 8'h00, 8'h02, 8'h00, 8'h00,
    8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0F, 8'h01};
  localparam logic [7:0] FR [4] = '{8'h01, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] FC [4] = '{8'h03, 8'h01, 8'h09, 8'h09};
  localparam logic [7:0] FK [4] = '{8'h01, 8'h01, 8'h03, 8'h00};
  localparam logic [7:0] TK [4] = '{8'h01, 8'h05, 8'h03, 8'h09};
  logic        clk_sys = 0, link_clk = 0, rst = 1, clr = 0;
  logic        cfg_wr = 0, cfg_rd = 0, pix_valid = 0, sof_pulse = 0;
  logic        four_capture_sel = 0, lv_low = 0, fs_low = 0, s, sw;
  logic [15:0] cfg_addr = 0;
  dvpo_byte_t  cfg_wdata = 0, cfg_rdata, d, v, pol, ch;
  logic [11:0] three_capture_combined = 0, four_capture_combined = 0;
  logic [11:0] vid_data, t, f, w, exp_q[$];
  logic        pix_ready, vid_line_valid, vid_frame_sync, vid_pclk;
  logic [1:0]  pc;
  int          miscompares = 0, samples_checked = 0, seed = 62, cyc = 0;
  int          stalled, wd, run;
  bit          first;

  dvpo_port #(.ROW_PERIOD(RP)) dut_u (.clk_sys, .rst, .link_clk,
    .cfg_addr, .cfg_wr, .cfg_rd, .cfg_wdata, .cfg_rdata, .four_capture_sel,
    .three_capture_combined, .four_capture_combined, .pix_valid,
    .pix_ready, .sof_pulse, .vid_data, .vid_line_valid, .vid_frame_sync,
    .vid_pclk);
  dvpo_rx_model rx_u (.link_clk, .clr, .lv_low, .fs_low, .vid_data,
    .vid_line_valid, .vid_frame_sync);

  // Clocks and hang limit
  always #20 clk_sys = ~clk_sys;
  initial
  begin
    #7;
    forever #80 link_clk = ~link_clk;
  end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      complete_run();
    end
  end

  // Shared helpers
  task automatic check(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [15:0] ra(int i);
    return 16'h4700 + 16'(i);
  endfunction
  function automatic logic [11:0] step(logic [11:0] x, int n, logic dn);
    logic [11:0] top;
    top = 12'h001 << n - 1;
    if (dn)
      return (x == 12'h001) ? top : x >> 1;
    return (x == top) ? 12'h001 : x << 1;
  endfunction
  task automatic wr(input logic [15:0] a, input dvpo_byte_t x);
    @(posedge clk_sys);
    cfg_addr <= a;
    cfg_wdata <= x;
    cfg_wr <= 1;
    @(posedge clk_sys);
    cfg_wr <= 0;
  endtask
  task automatic rd(input logic [15:0] a, output dvpo_byte_t x);
    @(posedge clk_sys);
    cfg_addr <= a;
    cfg_rd <= 1;
    @(posedge clk_sys);
    cfg_rd <= 0;
    @(posedge clk_sys);
    x = cfg_rdata;
  endtask
  task automatic wl(input int n);
    repeat (n) @(posedge link_clk);
    @(posedge clk_sys);
  endtask
  task automatic restart;
    wl(4);
    clr = 1;
    wl(2);
    clr = 0;
  endtask

  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst <= 0;
    for (int i = 0; i < 13; i++)
    begin
      rd(ra(i), d);
      check("reset value", d, RV[i]);
    end
    for (int i = 0; i < 13; i++)
    begin
      v = 8'($random(seed));
      if (i == 10)
        v = v & 8'h02;
      wr(ra(i), v);
      rd(ra(i), d);
      check("readback", d, v);
    end
    wr(16'h470D, 8'hA5);
    rd(16'h470D, d);
    check("unmapped read", d, 8'h00);
    for (int i = 0; i < 13; i++)
      wr(ra(i), RV[i]);
    $display("registers done");
    // Frame sync delay, width, polarity, bypass and enable
    wr(ra(2), 8'h00);
    wr(ra(5), 8'h00);
    wr(ra(6), 8'h05);
    for (int c = 0; c < 4; c++)
    begin
      fs_low = (c == 1);
      wr(ra(7), {6'h00, fs_low, 1'b0});
      wr(ra(1), FR[c]);
      wr(ra(3), FC[c]);
      wr(ra(12), FK[c]);
      restart();
      sof_pulse <= 1;
      @(posedge clk_sys);
      sof_pulse <= 0;
      wl(60);
      check("frame count", rx_u.fs_count, FK[c] != 0);
      check("frame width", rx_u.fs_len, FK[c][1] ? 2 : (FK[c][0] ?
        2 * (FR[c] * RP + FC[c]) : 0));
      if (FK[c] != 0)
        check("frame delay", rx_u.fs_at inside {[(FK[c][1] ? 1 : 11) :
          (FK[c][1] ? 8 : 18)]}, 1);
    end
    $display("frame sync done");
    // Pixel stream through the buffer, with stalls and pin options
    for (int r = 0; r < 2; r++)
    begin
      pol = r ? (8'($random(seed)) & 8'h44) : 8'h00;
      ch = r ? (8'($random(seed)) & 8'h0F) : 8'h0F;
      lv_low = pol[2];
      wr(ra(7), pol);
      wr(ra(11), ch);
      restart();
      exp_q.delete();
      stalled = 0;
      for (int n = 0; n < 20; n++)
      begin
        t = 12'($random(seed));
        f = 12'($random(seed));
        s = 1'($random(seed));
        three_capture_combined <= t;
        four_capture_combined <= f;
        four_capture_sel <= s;
        pix_valid <= 1;
        w = (s ? f : t) ^ {12{pol[6]}};
        for (int k = 0; k < 4; k++)
          if (!ch[k])
            w[3*k +: 3] = 3'h0;
        exp_q.push_back(w);
        @(posedge clk_sys);
        while (pix_ready !== 1'b1)
        begin
          stalled++;
          @(posedge clk_sys);
        end
      end
      pix_valid <= 0;
      wl(60);
      check("buffer stalled", stalled > 0, 1);
      check("word count", rx_u.words.size(), 20);
      for (int n = 0; n < 20; n++)
        check("pixel word", rx_u.words[n], exp_q[n]);
      check("line valid idle", vid_line_valid, lv_low);
    end
    $display("pixel stream done");
    // Walking one patterns in every width, direction and speed
    wr(ra(7), 8'h00);
    wr(ra(11), 8'h0F);
    lv_low = 0;
    for (int m = 0; m < 4; m++)
    begin
      sw = m[0];
      wr(ra(9), {2'b00, sw, 5'h00});
      wr(ra(8), TK[m]);
      restart();
      wl(48);
      wd = TK[m][2] ? 10 : (TK[m][1] ? 8 : 12);
      run = 0;
      first = 1;
      for (int i = 1; i < rx_u.words.size(); i++)
        if (rx_u.words[i] === rx_u.words[i-1])
          run++;
        else
        begin
          if (!first)
            check("pattern hold", run, TK[m][3]);
          first = 0;
          run = 0;
          check("pattern step", rx_u.words[i],
            step(rx_u.words[i-1], wd, sw));
        end
    end
    // Outgoing pixel clock level at data change, plain and inverted
    wr(ra(8), 8'h01);
    for (int k = 0; k < 2; k++)
    begin
      wr(ra(10), {6'h00, k[0], 1'b0});
      wl(6);
      repeat (2)
      begin
        w = vid_data;
        @(posedge link_clk);
        #1;
        if (vid_data !== w)
          pc[k] = vid_pclk;
      end
    end
    check("pixel clock invert", pc[0] ^ pc[1], 1);
    wr(ra(8), 8'h00);
    $display("test patterns done");
    complete_run();
  end
endmodule
